// >>> sim/far_side_model.sv
// core side memory and detector heartbeat model
module far_side_model
  import security_supervisor_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               hb_stall,
  input  wire logic [ADDR_W-1:0]  bus_addr,
  output logic      [DATA_W-1:0]  bus_rdata_mem,
  output logic      [NUM_DET-1:0] det_alive
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****
  // model
  // ****
  // data tracks the address, so a read of the wrong place shows up
  assign bus_rdata_mem = {~bus_addr, bus_addr};
  // heartbeat inverts each cycle unless stalled to fake a stuck line;
  // one register with a start value keeps a single driver on the output
  logic [NUM_DET-1:0] hb_q = 8'h55;
  assign det_alive = hb_q;
  always @(posedge clk) begin
    if (!hb_stall) hb_q <= #1 ~hb_q;
  end
endmodule : far_side_model

// >>> sim/security_supervisor_sva.sv
// port-level assertion checker for the security supervisor
module security_supervisor_sva
  import security_supervisor_pkg::*;
(
  input wire logic               clk,
  input wire logic               sys_rst,
  input wire logic               clk_en,
  input wire logic               priv,
  input wire logic               bus_req,
  input wire logic               opmode_we,
  input wire logic [NUM_DET-1:0] det_clear,
  input wire logic               go_normal,
  input wire logic               test_cmd,
  input wire logic               shield_breach,
  input wire logic [NUM_DET-1:0] det_status,
  input wire logic               core_halt,
  input wire logic               operating_mode_select,
  input wire logic [ADDR_W-1:0]  boot_vector,
  input wire logic               cfg_refused,
  input wire logic               test_mode,
  input wire logic               test_cmd_accept,
  input wire logic               bus_grant,
  input wire logic               bus_trap,
  input wire logic               invalid_addr,
  input wire logic [DATA_W-1:0]  bus_rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****
  // checks
  // ****
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // bits that no privileged clear hits this cycle must survive
  logic [NUM_DET-1:0] keep;
  assign keep = det_status & ~(priv ? det_clear : '0);
  answer_onehot_a:
    assert property (bus_req && clk_en |=> $onehot({bus_grant, bus_trap, invalid_addr}))
    else $error("bus request not answered exactly once");
  no_stray_a:
    assert property (!(bus_req && clk_en) |=> !(bus_grant || bus_trap || invalid_addr))
    else $error("bus answer without request");
  trap_data_a:
    assert property (bus_trap || invalid_addr |-> bus_rdata == TRAP_RDATA)
    else $error("refused access returned data");
  boot_vector_a:
    assert property (boot_vector == (operating_mode_select ? ROM_VECTOR : FLASH_VECTOR))
    else $error("boot vector does not follow mode");
  user_refused_a:
    assert property (opmode_we && !priv && clk_en |=> cfg_refused && $stable(operating_mode_select))
    else $error("user mode write not refused");
  flag_sticky_a:
    assert property (clk_en |=> (det_status & $past(keep)) == $past(keep))
    else $error("event flag lost without clear");
  shield_halt_a:
    assert property ($rose(shield_breach) |-> ##[1:6] core_halt ##1 core_halt)
    else $error("shield breach did not halt");
  one_way_a:
    assert property (go_normal && test_mode && clk_en |=> !test_mode [*8])
    else $error("test mode came back");
  normal_no_cmd_a:
    assert property (test_cmd && !test_mode && clk_en |=> !test_cmd_accept)
    else $error("test command accepted outside test mode");
endmodule : security_supervisor_sva

// >>> sim/test_security_supervisor.sv
// self-checking testbench for the security supervisor
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module test_security_supervisor;
  timeunit 1ns;
  timeprecision 100ps;
  import security_supervisor_pkg::*;
  // ****
  // signals
  // ****
  localparam logic [DATA_W-1:0] PWD = 32'h1357_2468; // arbitrary value
  logic clk, sys_rst, clk_en, ext_rst_pad, ext_clk_pad, shield_breach, priv, react_cfg_we;
  logic opmode_wdata, opmode_we, flash_wp_wdata, flash_wp_we, part_we, test_pwd_valid;
  logic go_normal, test_cmd, bus_req, bus_wr, bus_fetch, hb_stall, ext_rst_filt, ext_clk_filt;
  logic det_flag, lifetime_flag, chip_reset, core_halt, operating_mode_select, flash_wp;
  logic cfg_refused, test_mode, test_cmd_accept, bus_grant, bus_trap, invalid_addr;
  logic [NUM_DET-1:0] det_in, det_alive, det_status, react_cfg_wdata, det_clear, react_cfg;
  logic [1:0] part_sel;
  logic [3:0] part_attr_wdata;
  logic [ADDR_W-1:0] part_base_wdata, part_limit_wdata, boot_vector, bus_addr, lfsr;
  logic [DATA_W-1:0] test_pwd, bus_rdata_mem, bus_rdata;
  logic [DATA_W+1:0] e;
  logic [DATA_W+1:0] exp_q[$];
  reset_cause_t reset_cause;
  int bad_count = 0;
  int n_checks = 0;
  security_supervisor #(.TEST_PASSWORD(PWD)) security_supervisor_i (.*);
  far_side_model far_side_model_i (.*);
  // 200 MHz clock
  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end
  task step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  function automatic logic [15:0] nxt(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : nxt
  // request stays up between calls so accesses run back to back
  task acc(input logic wr, input logic [15:0] a, input logic [1:0] k);
    bus_req = 1'h1;
    bus_wr = wr;
    bus_addr = a;
    exp_q.push_back({k, (k == 2'h0 && !wr) ? {~a, a} : 32'h0});
    step(1);
  endtask : acc
  // answers are matched in order; kind 0 grant, 1 trap, 2 invalid
  always @(negedge clk) begin
    if (bus_grant || bus_trap || invalid_addr) begin
      e = exp_q.size() ? exp_q.pop_front() : '1;
      `CHK("bus answer", e[33:32], {invalid_addr, bus_trap})
      `CHK("bus data", e[31:0], bus_rdata)
    end
  end
  task wrap_up;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : wrap_up
  // the run needs under a thousand ns; a hang gets cut well after that
  initial begin
    #5000;
    bad_count++;
    wrap_up();
  end
  // ****
  // scenarios
  // ****
  initial begin
    {ext_rst_pad, ext_clk_pad, shield_breach, priv, react_cfg_we, opmode_wdata} = '0;
    {opmode_we, flash_wp_wdata, flash_wp_we, part_we, test_pwd_valid, go_normal} = '0;
    {test_cmd, bus_req, bus_wr, bus_fetch, hb_stall, det_in, react_cfg_wdata} = '0;
    {det_clear, part_sel, part_attr_wdata, part_base_wdata, part_limit_wdata} = '0;
    {bus_addr, test_pwd} = '0;
    lfsr = 16'h002d;
    clk_en = 1'h1;
    sys_rst = 1'h1;
    step(2);
    sys_rst = 1'h0;
    `CHK("reset cfg", 18'h30000, {operating_mode_select, flash_wp, boot_vector})
    `CHK("reset state", 18'h0, {det_status, react_cfg, test_mode, core_halt})
    priv = 1'h1;
    acc(1'h0, 16'h0100, 2'h0);
    acc(1'h0, 16'hc000, 2'h2);
    acc(1'h1, 16'h2000, 2'h1);
    acc(1'h0, 16'hf010, 2'h0);
    priv = 1'h0;
    acc(1'h0, 16'hf010, 2'h1);
    acc(1'h0, 16'h2010, 2'h1);
    acc(1'h0, 16'ha010, 2'h1);
    bus_req = 1'h0;
    {part_base_wdata, part_limit_wdata, part_attr_wdata} = {16'h2000, 16'h20ff, 4'h9};
    {part_we, opmode_we} = 2'h3;
    step(1);
    `CHK("user cfg", 2'h3, {cfg_refused, operating_mode_select})
    {priv, opmode_we} = 2'h2;
    step(1);
    {priv, part_we} = 2'h0;
    acc(1'h0, 16'h2010, 2'h0);
    acc(1'h0, 16'h2100, 2'h1);
    acc(1'h1, 16'h2010, 2'h1);
    // the partition grants read only, so a user fetch there must trap
    bus_fetch = 1'h1;
    acc(1'h0, 16'h2010, 2'h1);
    bus_fetch = 1'h0;
    priv = 1'h1;
    repeat (8) begin
      lfsr = nxt(lfsr);
      acc(1'h0, 16'ha000 | (lfsr & 16'h1fff), 2'h0);
    end
    bus_req = 1'h0;
    {opmode_we, flash_wp_we} = 2'h3;
    step(1);
    {opmode_we, flash_wp_we} = 2'h0;
    `CHK("flash boot", 17'h04000, {boot_vector, flash_wp})
    acc(1'h0, 16'h0100, 2'h1);
    acc(1'h1, 16'h2000, 2'h0);
    acc(1'h1, 16'h9f10, 2'h0);
    bus_req = 1'h0;
    $display("access tests done");
    test_cmd = 1'h1;
    step(1);
    `CHK("no password", 1'h0, test_cmd_accept)
    {test_pwd_valid, test_pwd} = {1'h1, ~PWD};
    step(1);
    `CHK("bad password", 1'h0, test_mode)
    test_pwd = PWD;
    step(2);
    `CHK("test cmd", 2'h3, {test_mode, test_cmd_accept})
    {test_pwd_valid, go_normal} = 2'h1;
    step(1);
    `CHK("to normal", 1'h0, test_mode)
    {test_pwd_valid, go_normal} = 2'h2;
    step(2);
    `CHK("normal", 2'h0, {test_mode, test_cmd_accept})
    {test_pwd_valid, test_cmd} = 2'h0;
    acc(1'h1, 16'h9f10, 2'h1);
    acc(1'h0, 16'h9f10, 2'h0);
    bus_req = 1'h0;
    $display("lifecycle tests done");
    {react_cfg_we, react_cfg_wdata} = {1'h1, 8'h01};
    step(1);
    react_cfg_we = 1'h0;
    det_in = 8'h02;
    step(3);
    `CHK("flag event", 18'h0040a, {react_cfg, det_status, det_flag, chip_reset})
    {det_in, priv, det_clear} = {8'h00, 1'h0, 8'h02};
    step(4);
    `CHK("sticky", 8'h02, det_status)
    priv = 1'h1;
    step(1);
    det_clear = 8'h00;
    `CHK("cleared", 8'h00, det_status)
    det_in = 8'h01;
    step(3);
    `CHK("reset event", {1'h1, RC_DETECTOR}, {chip_reset, reset_cause})
    {det_in, hb_stall} = 9'h001;
    step(4);
    hb_stall = 1'h0;
    step(3);
    `CHK("lifetime", 1'h1, lifetime_flag)
    // an event while the enable is low must wait until it comes back
    {clk_en, det_in} = 9'h004;
    step(4);
    `CHK("frozen", 8'h01, det_status)
    clk_en = 1'h1;
    step(3);
    `CHK("resumed", 8'h05, det_status)
    det_in = 8'h00;
    $display("detector tests done");
    {ext_rst_pad, ext_clk_pad} = 2'h3;
    step(3);
    {ext_rst_pad, ext_clk_pad} = 2'h0;
    step(20);
    `CHK("short pulse", 2'h0, {ext_rst_filt, ext_clk_filt})
    {ext_rst_pad, ext_clk_pad} = 2'h3;
    step(10);
    `CHK("clk pad", 2'h1, {ext_rst_filt, ext_clk_filt})
    step(10);
    `CHK("rst pad", 2'h3, {ext_rst_filt, ext_clk_filt})
    shield_breach = 1'h1;
    step(6);
    `CHK("shield", {1'h1, RC_SHIELD}, {core_halt, reset_cause})
    acc(1'h0, 16'ha000, 2'h1);
    bus_req = 1'h0;
    step(3);
    `CHK("all answered", 0, exp_q.size())
    $display("pad and shield tests done");
    // a second power-on reset must clear halt, cause and lifetime alike
    {sys_rst, shield_breach} = 2'h2;
    step(2);
    sys_rst = 1'h0;
    step(4);
    `CHK("rerun", {3'h1, RC_NONE}, {core_halt, lifetime_flag, flash_wp, reset_cause})
    $display("reset tests done");
    wrap_up();
  end
endmodule : test_security_supervisor
bind security_supervisor security_supervisor_sva security_supervisor_sva_i (.*);

// >>> src/mpu_cfg_if.sv
// interface carrying partition configuration and access checks
interface mpu_cfg_if;
  import security_supervisor_pkg::*;

  logic [ADDR_W-1:0] base  [NUM_PART];
  logic [ADDR_W-1:0] limit [NUM_PART];
  logic [3:0]        attr  [NUM_PART];
  logic [ADDR_W-1:0] addr;
  logic              wr;
  logic              fetch;
  logic              allow;

  modport cfg (output base, output limit, output attr, output addr, output wr,
               output fetch, input allow);
  modport chk (input base, input limit, input attr, input addr, input wr,
               input fetch, output allow);
endinterface : mpu_cfg_if

// >>> src/mpu_checker.sv
// partition range match and attribute check for user-mode accesses
module mpu_checker
  import security_supervisor_pkg::*;
(
  mpu_cfg_if.chk cfg
);
  import security_supervisor_pkg::*;

  // ***************************************************************
  // partition match
  // ***************************************************************
  // first enabled partition that covers the address decides; none denies
  always_comb begin
    cfg.allow = 1'b0;
    for (int i = NUM_PART - 1; i >= 0; i--) begin
      if (cfg.attr[i][ATTR_EN] && cfg.addr >= cfg.base[i] &&
          cfg.addr <= cfg.limit[i]) begin
        cfg.allow = cfg.fetch ? cfg.attr[i][ATTR_X] :
                    cfg.wr    ? cfg.attr[i][ATTR_W] : cfg.attr[i][ATTR_R];
      end
    end
  end

endmodule : mpu_checker

// >>> src/pulse_filter.sv
// glitch and high-frequency filter for one external pad input
module pulse_filter
  import security_supervisor_pkg::*;
#(
  parameter logic [FILT_CNT_W-1:0] MIN_CYC = FILT_CNT_W'(RST_FILT_CYC)
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic clk_en,
  input  wire logic pad_in,
  output logic      filt_out
);
  import security_supervisor_pkg::*;

  typedef struct packed {
    logic                  sync1;
    logic                  sync2;
    filt_state_t           st;
    logic [FILT_CNT_W-1:0] cnt;
    logic                  level;
  } filt_regs_t;

  filt_regs_t r_q;
  filt_regs_t r_d;

  // ***************************************************************
  // pulse width qualification
  // ***************************************************************
  // a new level is only accepted after it held for MIN_CYC cycles
  always_comb begin
    r_d       = r_q;
    r_d.sync1 = pad_in;
    r_d.sync2 = r_q.sync1;
    case (r_q.st)
      FR_IDLE: begin
        if (r_q.sync2 != r_q.level) begin
          r_d.st  = FR_COUNT;
          r_d.cnt = FILT_CNT_W'(1);
        end
      end
      FR_COUNT: begin
        if (r_q.sync2 == r_q.level) begin
          r_d.st = FR_IDLE; // glitch, drop it
        end else if (r_q.cnt >= MIN_CYC) begin
          r_d.st = FR_PASS;
        end else begin
          r_d.cnt = r_q.cnt + FILT_CNT_W'(1);
        end
      end
      FR_PASS: begin
        r_d.level = r_q.sync2;
        r_d.st    = FR_IDLE;
      end
      default: r_d.st = FR_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      r_q <= '0;
    end else if (clk_en) begin
      r_q <= r_d;
    end
  end

  assign filt_out = r_q.level;

endmodule : pulse_filter

// >>> src/security_supervisor.sv
// security supervisor: detectors, pad filters, access control, lifecycle
module security_supervisor
  import security_supervisor_pkg::*;
#(
  parameter logic [DATA_W-1:0] TEST_PASSWORD = 32'h5a5a_c3c3 // arbitrary value
) (
  input  wire logic                           clk,
  input  wire logic                           sys_rst,
  input  wire logic                           clk_en,
  // external pads
  input  wire logic                           ext_rst_pad,
  input  wire logic                           ext_clk_pad,
  output logic                                ext_rst_filt,
  output logic                                ext_clk_filt,
  // detectors
  input  wire logic [security_supervisor_pkg::NUM_DET-1:0] det_in,
  input  wire logic [security_supervisor_pkg::NUM_DET-1:0] det_alive,
  input  wire logic                           shield_breach,
  output logic [security_supervisor_pkg::NUM_DET-1:0]      det_status,
  output logic                                det_flag,
  output logic                                lifetime_flag,
  output logic                                chip_reset,
  output logic                                core_halt,
  output security_supervisor_pkg::reset_cause_t            reset_cause,
  // control from core
  input  wire logic                           priv,
  input  wire logic [security_supervisor_pkg::NUM_DET-1:0] react_cfg_wdata,
  input  wire logic                           react_cfg_we,
  input  wire logic [security_supervisor_pkg::NUM_DET-1:0] det_clear,
  input  wire logic                           opmode_wdata,
  input  wire logic                           opmode_we,
  input  wire logic                           flash_wp_wdata,
  input  wire logic                           flash_wp_we,
  input  wire logic [1:0]                     part_sel,
  input  wire logic [security_supervisor_pkg::ADDR_W-1:0]  part_base_wdata,
  input  wire logic [security_supervisor_pkg::ADDR_W-1:0]  part_limit_wdata,
  input  wire logic [3:0]                     part_attr_wdata,
  input  wire logic                           part_we,
  output logic [security_supervisor_pkg::NUM_DET-1:0]      react_cfg,
  output logic                                operating_mode_select,
  output logic                                flash_wp,
  output logic [security_supervisor_pkg::ADDR_W-1:0]       boot_vector,
  output logic                                cfg_refused,
  // lifecycle
  input  wire logic [security_supervisor_pkg::DATA_W-1:0]  test_pwd,
  input  wire logic                           test_pwd_valid,
  input  wire logic                           go_normal,
  input  wire logic                           test_cmd,
  output logic                                test_mode,
  output logic                                test_cmd_accept,
  // internal bus request from core
  input  wire logic                           bus_req,
  input  wire logic                           bus_wr,
  input  wire logic                           bus_fetch,
  input  wire logic [security_supervisor_pkg::ADDR_W-1:0]  bus_addr,
  input  wire logic [security_supervisor_pkg::DATA_W-1:0]  bus_rdata_mem,
  output logic                                bus_grant,
  output logic [security_supervisor_pkg::DATA_W-1:0]       bus_rdata,
  output logic                                bus_trap,
  output logic                                invalid_addr
);
  import security_supervisor_pkg::*;

  typedef struct packed {
    logic [NUM_DET-1:0]   det_sync1;
    logic [NUM_DET-1:0]   det_sync2;
    logic [NUM_DET-1:0]   alive_sync1;
    logic [NUM_DET-1:0]   alive_sync2;
    logic [NUM_DET-1:0]   alive_prev;
    logic [1:0]           alive_arm;
    logic                 shield_sync1;
    logic                 shield_sync2;
    logic [NUM_DET-1:0]   status;
    logic [NUM_DET-1:0]   react;
    logic                 lifetime;
    logic                 halt;
    logic                 rst_pulse;
    reset_cause_t         cause;
    logic                 opmode;
    logic                 wp;
    logic                 refused;
    lifecycle_t           lc;
    logic                 test_ok;
    logic                 cmd_ok;
    logic                 grant;
    logic                 trap;
    logic                 invalid;
    logic [DATA_W-1:0]    rdata;
    logic [NUM_PART-1:0][ADDR_W-1:0] base;
    logic [NUM_PART-1:0][ADDR_W-1:0] limit;
    logic [NUM_PART-1:0][3:0]        attr;
  } sup_regs_t;

  sup_regs_t r_q;
  sup_regs_t r_d;

  mpu_cfg_if mpu ();

  // ***************************************************************
  // pad filters
  // ***************************************************************
  pulse_filter #(.MIN_CYC(FILT_CNT_W'(RST_FILT_CYC))) u_rst_filt (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .clk_en   (clk_en),
    .pad_in   (ext_rst_pad),
    .filt_out (ext_rst_filt)
  );

  pulse_filter #(.MIN_CYC(FILT_CNT_W'(CLK_MIN_CYC))) u_clk_filt (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .clk_en   (clk_en),
    .pad_in   (ext_clk_pad),
    .filt_out (ext_clk_filt)
  );

  // ***************************************************************
  // partition checker
  // ***************************************************************
  for (genvar i = 0; i < NUM_PART; i++) begin : g_part
    assign mpu.base[i]  = r_q.base[i];
    assign mpu.limit[i] = r_q.limit[i];
    assign mpu.attr[i]  = r_q.attr[i];
  end
  assign mpu.addr  = bus_addr;
  assign mpu.wr    = bus_wr;
  assign mpu.fetch = bus_fetch;

  mpu_checker u_mpu (
    .cfg (mpu)
  );

  // ***************************************************************
  // address classification
  // ***************************************************************
  logic in_rom;
  logic in_flash;
  logic in_ram;
  logic in_sfr;
  logic in_trace;
  logic mapped;
  logic prohibited;

  always_comb begin
    in_rom   = bus_addr <= ROM_LIMIT;
    in_flash = bus_addr >= FLASH_BASE && bus_addr <= FLASH_LIM;
    in_trace = bus_addr >= TRACE_BASE && bus_addr <= FLASH_LIM;
    in_ram   = bus_addr >= RAM_BASE && bus_addr <= RAM_LIMIT;
    in_sfr   = bus_addr >= SFR_BASE && bus_addr <= SFR_LIMIT;
    mapped   = in_rom | in_flash | in_ram | in_sfr;
    prohibited = 1'b0;
    // rom is only reachable when booting from rom
    if (in_rom && !r_q.opmode) begin
      prohibited = 1'b1;
    end
    if (in_sfr && !priv) begin
      prohibited = 1'b1;
    end
    if (bus_wr && in_flash && r_q.wp) begin
      prohibited = 1'b1;
    end
    if (bus_wr && in_trace && r_q.lc == LC_NORMAL) begin
      prohibited = 1'b1;
    end
    if (!priv && (in_flash || in_ram) && !mpu.allow) begin
      prohibited = 1'b1;
    end
  end

  // ***************************************************************
  // next state
  // ***************************************************************
  logic [NUM_DET-1:0] det_fire;
  logic               cfg_ok;

  always_comb begin
    r_d = r_q;
    r_d.det_sync1    = det_in;
    r_d.det_sync2    = r_q.det_sync1;
    r_d.alive_sync1  = det_alive;
    r_d.alive_sync2  = r_q.alive_sync1;
    r_d.alive_prev   = r_q.alive_sync2;
    r_d.shield_sync1 = shield_breach;
    r_d.shield_sync2 = r_q.shield_sync1;
    cfg_ok = priv;

    // detection is unconditional; clear only in privileged mode, set wins
    det_fire = r_q.det_sync2;
    r_d.status = (r_q.status & ~(priv ? det_clear : '0)) | det_fire;

    // reaction choice: bit high selects reset, low selects flag
    r_d.rst_pulse = |(det_fire & r_q.react);
    if (|(det_fire & r_q.react)) begin
      r_d.cause = RC_DETECTOR;
    end

    // alive lines must toggle every cycle; a stuck one means tampering.
    // the compare waits until two real samples sit in the chain, since
    // the zeros left by reset would look like a stuck line
    if (r_q.alive_arm != 2'h3) begin
      r_d.alive_arm = r_q.alive_arm + 2'h1;
    end
    if (r_q.alive_arm == 2'h3 && (r_q.alive_sync2 ~^ r_q.alive_prev) != '0) begin
      r_d.lifetime = 1'b1;
      r_d.cause    = RC_LIFETIME;
    end else if (priv && r_q.lifetime && det_clear[0]) begin
      r_d.lifetime = 1'b0;
    end

    // shield breach halts the core until the next power-on reset
    if (r_q.shield_sync2) begin
      r_d.halt  = 1'b1;
      r_d.cause = RC_SHIELD;
    end

    // privileged configuration writes
    r_d.refused = 1'b0;
    if (react_cfg_we || opmode_we || flash_wp_we || part_we) begin
      r_d.refused = !cfg_ok;
    end
    if (cfg_ok && react_cfg_we) begin
      r_d.react = react_cfg_wdata;
    end
    if (cfg_ok && opmode_we) begin
      r_d.opmode = opmode_wdata;
    end
    if (cfg_ok && flash_wp_we) begin
      r_d.wp = flash_wp_wdata;
    end
    if (cfg_ok && part_we) begin
      r_d.base[part_sel]  = part_base_wdata;
      r_d.limit[part_sel] = part_limit_wdata;
      r_d.attr[part_sel]  = part_attr_wdata;
    end

    // lifecycle: password gates test entry, normal is terminal
    case (r_q.lc)
      LC_TEST: begin
        if (test_pwd_valid) begin
          r_d.test_ok = (test_pwd == TEST_PASSWORD);
        end
        if (go_normal && r_q.test_ok) begin
          r_d.lc      = LC_NORMAL;
          r_d.test_ok = 1'b0;
        end
      end
      LC_NORMAL: begin
        r_d.lc      = LC_NORMAL;
        r_d.test_ok = 1'b0;
      end
      default: r_d.lc = LC_NORMAL;
    endcase
    r_d.cmd_ok = test_cmd && r_q.lc == LC_TEST && r_q.test_ok;

    // bus answer, one cycle after the request
    r_d.grant   = bus_req && mapped && !prohibited && !r_q.halt;
    r_d.trap    = bus_req && mapped && (prohibited || r_q.halt);
    r_d.invalid = bus_req && !mapped;
    r_d.rdata   = (bus_req && mapped && !prohibited && !r_q.halt && !bus_wr) ?
                  bus_rdata_mem : TRAP_RDATA;
  end

  // ***************************************************************
  // state register
  // ***************************************************************
  // reset cause lives on through the detector-triggered reset since
  // that reset goes to the rest of the chip, not to this block
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      r_q <= '0;
      r_q.opmode <= 1'b1; // boot from rom by default
      r_q.wp     <= 1'b1;
      for (int i = 0; i < NUM_PART; i++) begin
        r_q.attr[i] <= ATTR_RST;
      end
    end else if (clk_en) begin
      r_q <= r_d;
    end
  end

  // ***************************************************************
  // outputs
  // ***************************************************************
  assign det_status            = r_q.status;
  assign det_flag              = |(r_q.status & ~r_q.react);
  assign lifetime_flag         = r_q.lifetime;
  assign chip_reset            = r_q.rst_pulse;
  assign core_halt             = r_q.halt;
  assign reset_cause           = r_q.cause;
  assign react_cfg             = r_q.react;
  assign operating_mode_select = r_q.opmode;
  assign flash_wp              = r_q.wp;
  assign boot_vector           = r_q.opmode ? ROM_VECTOR : FLASH_VECTOR;
  assign cfg_refused           = r_q.refused;
  assign test_mode             = r_q.lc == LC_TEST && r_q.test_ok;
  assign test_cmd_accept       = r_q.cmd_ok;
  assign bus_grant             = r_q.grant;
  assign bus_rdata             = r_q.rdata;
  assign bus_trap              = r_q.trap;
  assign invalid_addr          = r_q.invalid;

endmodule : security_supervisor

// >>> src/security_supervisor_pkg.sv
// package with constants and types for the security supervisor
package security_supervisor_pkg;

  // ***************************************************************
  // sizes
  // ***************************************************************
  localparam int unsigned NUM_DET    = 8;
  localparam int unsigned ADDR_W     = 16;
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned NUM_PART   = 4;

  // ***************************************************************
  // filter timing
  // ***************************************************************
  localparam int unsigned CLK_MHZ         = 200;
  localparam int unsigned RST_FILT_NS     = 50;
  localparam int unsigned RST_FILT_CYC    = (RST_FILT_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CLK_MIN_HIGH_NS = 20;
  localparam int unsigned CLK_MIN_CYC     = (CLK_MIN_HIGH_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned FILT_CNT_W      = 8;

  // ***************************************************************
  // address map of the internal bus
  // ***************************************************************
  localparam logic [ADDR_W-1:0] ROM_BASE   = 16'h0000;
  localparam logic [ADDR_W-1:0] ROM_LIMIT  = 16'h1fff;
  localparam logic [ADDR_W-1:0] FLASH_BASE = 16'h2000;
  localparam logic [ADDR_W-1:0] FLASH_LIM  = 16'h9fff;
  localparam logic [ADDR_W-1:0] TRACE_BASE = 16'h9f00;
  localparam logic [ADDR_W-1:0] RAM_BASE   = 16'ha000;
  localparam logic [ADDR_W-1:0] RAM_LIMIT  = 16'hbfff;
  localparam logic [ADDR_W-1:0] SFR_BASE   = 16'hf000;
  localparam logic [ADDR_W-1:0] SFR_LIMIT  = 16'hf0ff;

  // reset vectors chosen by the boot selection
  localparam logic [ADDR_W-1:0] ROM_VECTOR   = ROM_BASE;
  localparam logic [ADDR_W-1:0] FLASH_VECTOR = FLASH_BASE;

  // value returned by a refused read
  localparam logic [DATA_W-1:0] TRAP_RDATA = 32'h0000_0000;

  // ***************************************************************
  // partition attribute bits and reset defaults
  // ***************************************************************
  localparam int unsigned ATTR_R   = 0;
  localparam int unsigned ATTR_W   = 1;
  localparam int unsigned ATTR_X   = 2;
  localparam int unsigned ATTR_EN  = 3;
  localparam logic [3:0]  ATTR_RST = 4'h0;

  // ***************************************************************
  // types
  // ***************************************************************
  typedef enum logic [1:0] {
    LC_TEST   = 2'b00,
    LC_NORMAL = 2'b01
  } lifecycle_t;

  typedef enum logic [1:0] {
    FR_IDLE  = 2'b00,
    FR_COUNT = 2'b01,
    FR_PASS  = 2'b10
  } filt_state_t;

  typedef enum logic [1:0] {
    RC_NONE     = 2'b00,
    RC_DETECTOR = 2'b01,
    RC_SHIELD   = 2'b10,
    RC_LIFETIME = 2'b11
  } reset_cause_t;

endpackage : security_supervisor_pkg
